// ===== arop_readout.v
// result readout port: 16-bit parallel, byte-wide parallel and two-line serial
// Notes on behaviour
// [RULE1] two select inputs choose 16-bit parallel, serial or byte-wide readout
// [RULE2] busy falling edge marks new results ready on every interface
// [RULE3] 16-bit mode drives the data bus only while chip select and read low
// [RULE4] chip select rise floats the bus, its fall releases it
// [RULE5] each read falling edge presents the next channel, channel 1 first
// [RULE6] host may read old results during busy, chip select may stay low
// [RULE7] joined chip select and read: each low pulse frames one channel
// [RULE8] byte mode needs two read pulses per channel result
// [RULE9] byte mode needs interface select and byte select both held high
// [RULE10] byte mode carries each byte on lines 7 to 0, line 0 lsb
// [RULE11] high byte first input chooses upper or lower byte first
// [RULE12] byte mode first channel flag stays high until channel 1 fully read
// [RULE13] serial mode moves data with chip select and serial clock only
// [RULE14] serial line a starts with channels 1 and 2, line b with 3 and 4
// [RULE15] chip select fall releases serial lines with msb, clock rise shifts
// [RULE16] host gives 16 serial clocks per channel, any chip select framing
// [RULE17] host samples serial bits on falling clock edges
// [RULE18] a single serial line still carries every channel in turn
// [RULE19] line b alone gives order channel 3, 4, 1, 2
// [RULE20] serial flag floats while deselected, high for channel 1 on line a
// [RULE21] flag never rises while channel 1 is on line b
// [RULE22] reads during busy deliver the previous conversion's results
// [RULE23] output registers load new results at the busy falling edge
// [RULE24] new results reset the channel read pointer to channel 1
`timescale 1ns/1ns
`default_nettype none
`include "arop_defines.vh"
module arop_readout (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst,
   // converter side
   input  wire        i_busy,
   input  wire [63:0] i_conv_results,
   input  wire        i_conv_valid,
   output reg         o_conv_ready,
   // mode straps
   input  wire        i_interface_select,
   // host strobes
   input  wire        i_cs_n,
   input  wire        i_rd_n,
   input  wire        i_sclk,
   // result bus, pins 15 and 14 are byte mode inputs too
   input  wire [15:0] i_result_bus,
   output reg  [15:0] o_result_bus,
   output reg  [15:0] o_result_bus_oe,
   // serial outputs
   output reg         o_serial_out_a,
   output reg         o_serial_out_a_oe,
   output reg         o_serial_out_b,
   output reg         o_serial_out_b_oe,
   // first channel flag
   output reg         o_first_channel_flag,
   output reg         o_first_channel_flag_oe
);
   localparam ST_IDLE = 3'b001;
   localparam ST_PAR  = 3'b010;
   localparam ST_SER  = 3'b100;

   // synchronisers: first stage feeds only the second
   reg [4:0]  s1_q;
   reg [4:0]  s2_q;
   reg [4:0]  s3_q;
   reg [1:0]  bsel_s1_q;
   reg [1:0]  bsel_s2_q;
   wire       busy_s;
   wire       cs_n_s;
   wire       rd_n_s;
   wire       sclk_s;
   wire       isel_s;
   wire       byte_mode_select;
   wire       high_byte_first;
   wire       busy_fall;
   wire       cs_fall;
   wire       cs_rise;
   wire       rd_fall;
   wire       sclk_rise;
   wire       sclk_fall;
   wire [1:0] if_mode;
   wire       par_rd;

   reg [15:0]             res_q [0:`AROP_CHANNELS-1];
   reg [`AROP_CH_W-1:0]   ptr_q;
   reg                    byte_hi_q;
   reg [2:0]              st_q;
   reg [`AROP_CH_W-1:0]   ser_idx_q;
   reg [4:0]              bit_q;
   reg [15:0]             sha_q;
   reg [15:0]             shb_q;
   wire                   fifo_valid;
   wire [63:0]            fifo_data;
   wire                   fifo_wr_ready;
   integer                k;

   // channel carried by serial line a or b at a given slot
   function [`AROP_CH_W-1:0] ser_ch;
      input [`AROP_CH_W-1:0] idx;
      input                  line_b;
      begin
         ser_ch = idx + (line_b ? 2'h2 : 2'h0);
      end
   endfunction

   // byte pick honouring the byte order input
   function [7:0] pick_byte;
      input [15:0] w;
      input        hi_first;
      input        second;
      begin
         pick_byte = (hi_first ^ second) ? w[15:8] : w[7:0];
      end
   endfunction

   assign busy_s           = s2_q[0];
   assign cs_n_s           = s2_q[1];
   assign rd_n_s           = s2_q[2];
   assign sclk_s           = s2_q[3];
   assign isel_s           = s2_q[4];
   assign byte_mode_select = bsel_s2_q[1];
   assign high_byte_first  = bsel_s2_q[0];
   assign busy_fall        = s3_q[0] && !busy_s;                  // [RULE2]
   assign cs_fall          = s3_q[1] && !cs_n_s;
   assign cs_rise          = !s3_q[1] && cs_n_s;
   assign rd_fall          = s3_q[2] && !rd_n_s;
   assign sclk_rise        = !s3_q[3] && sclk_s;
   assign sclk_fall        = s3_q[3] && !sclk_s;
   assign if_mode          = {isel_s & byte_mode_select, isel_s}; // [RULE1] [RULE9]
   // a read strobe counts only while selected and outside a serial frame
   assign par_rd           = rd_fall && !cs_n_s && (st_q != ST_SER)
                             && (if_mode != `AROP_IF_SERIAL);

   arop_fifo #(
      .WIDTH (64),
      .DEPTH (`AROP_FIFO_DEPTH),
      .AW    (`AROP_FIFO_AW)
   ) u_fifo (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_wr_valid (i_conv_valid),
      .o_wr_ready (fifo_wr_ready),
      .i_wr_data  (i_conv_results),
      .o_rd_valid (fifo_valid),
      .i_rd_ready (busy_fall),
      .o_rd_data  (fifo_data)
   );

   always @(posedge i_clk) begin
      if (i_rst) begin
         s1_q      <= 5'h1E;
         s2_q      <= 5'h1E;
         s3_q      <= 5'h1E;
         bsel_s1_q <= 2'h0;
         bsel_s2_q <= 2'h0;
      end else begin
         s1_q      <= {i_interface_select, i_sclk, i_rd_n, i_cs_n, i_busy};
         s2_q      <= s1_q;
         s3_q      <= s2_q;
         bsel_s1_q <= {i_result_bus[15], i_result_bus[14]};
         bsel_s2_q <= bsel_s1_q;
      end
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         for (k = 0; k < `AROP_CHANNELS; k = k + 1) begin
            res_q[k] <= 16'h0000;
         end
         ptr_q                   <= {`AROP_CH_W{1'b0}};
         byte_hi_q               <= 1'b0;
         st_q                    <= ST_IDLE;
         ser_idx_q               <= {`AROP_CH_W{1'b0}};
         bit_q                   <= 5'h00;
         sha_q                   <= 16'h0000;
         shb_q                   <= 16'h0000;
         o_conv_ready            <= 1'b0;
         o_result_bus            <= 16'h0000;
         o_result_bus_oe         <= 16'h0000;
         o_serial_out_a          <= 1'b0;
         o_serial_out_a_oe       <= 1'b0;
         o_serial_out_b          <= 1'b0;
         o_serial_out_b_oe       <= 1'b0;
         o_first_channel_flag    <= 1'b0;
         o_first_channel_flag_oe <= 1'b0;
      end else begin
         o_conv_ready <= fifo_wr_ready;
         // results change only here, so busy-high reads see the old set
         if (busy_fall && fifo_valid) begin                       // [RULE23] [RULE22]
            for (k = 0; k < `AROP_CHANNELS; k = k + 1) begin
               res_q[k] <= fifo_data[16*k +: 16];
            end
         end
         if (busy_fall) begin
            ptr_q     <= {`AROP_CH_W{1'b0}};                      // [RULE24]
            byte_hi_q <= 1'b0;
            ser_idx_q <= {`AROP_CH_W{1'b0}};
         end
         case (st_q)
            ST_IDLE: begin
               o_result_bus_oe   <= 16'h0000;
               o_serial_out_a_oe <= 1'b0;
               o_serial_out_b_oe <= 1'b0;
               o_first_channel_flag_oe <= 1'b0;
               if (cs_fall || (!cs_n_s && if_mode != `AROP_IF_SERIAL)) begin // [RULE4] [RULE6]
                  if (if_mode == `AROP_IF_SERIAL) begin           // [RULE13]
                     st_q <= ST_SER;
                     // msb is on the line at chip select fall
                     sha_q <= res_q[ser_ch(ser_idx_q, 1'b0)];     // [RULE14] [RULE15]
                     shb_q <= res_q[ser_ch(ser_idx_q, 1'b1)];
                     o_serial_out_a    <= res_q[ser_ch(ser_idx_q, 1'b0)][15];
                     o_serial_out_b    <= res_q[ser_ch(ser_idx_q, 1'b1)][15];
                     o_serial_out_a_oe <= 1'b1;
                     o_serial_out_b_oe <= 1'b1;
                     bit_q             <= 5'h00;
                     o_first_channel_flag    <= (ser_idx_q == 2'h0); // [RULE20] [RULE21]
                     o_first_channel_flag_oe <= 1'b1;
                  end else begin
                     st_q <= ST_PAR;
                  end
               end
            end
            ST_PAR: begin
               if (cs_rise || if_mode == `AROP_IF_SERIAL) begin
                  st_q            <= ST_IDLE;
                  o_result_bus_oe <= 16'h0000;                    // [RULE4]
               end else begin
                  if (if_mode == `AROP_IF_BYTE) begin
                     // pins 15 and 14 stay inputs in byte mode
                     o_result_bus_oe <= (rd_n_s || cs_n_s) ? 16'h0000 : 16'h00FF;
                  end else begin
                     o_result_bus_oe <= (rd_n_s || cs_n_s) ? 16'h0000 : 16'hFFFF; // [RULE3]
                  end
               end
            end
            ST_SER: begin
               if (cs_rise) begin
                  st_q                    <= ST_IDLE;
                  o_serial_out_a_oe       <= 1'b0;
                  o_serial_out_b_oe       <= 1'b0;
                  o_first_channel_flag_oe <= 1'b0;                // [RULE20]
               end else begin
                  if (sclk_rise && bit_q != 5'h00) begin          // [RULE15]
                     if (bit_q == `AROP_BITS_PER_CH) begin
                        // next channel slot on each line
                        sha_q <= res_q[ser_ch(ser_idx_q, 1'b0)];  // [RULE18] [RULE19]
                        shb_q <= res_q[ser_ch(ser_idx_q, 1'b1)];
                        o_serial_out_a <= res_q[ser_ch(ser_idx_q, 1'b0)][15];
                        o_serial_out_b <= res_q[ser_ch(ser_idx_q, 1'b1)][15];
                        bit_q <= 5'h00;
                        o_first_channel_flag <= (ser_idx_q == 2'h0); // [RULE21]
                     end else begin
                        sha_q <= {sha_q[14:0], 1'b0};
                        shb_q <= {shb_q[14:0], 1'b0};
                        o_serial_out_a <= sha_q[14];
                        o_serial_out_b <= shb_q[14];
                     end
                  end
                  if (sclk_fall) begin                            // [RULE16] [RULE17]
                     if (bit_q == `AROP_BITS_PER_CH - 5'h01) begin
                        ser_idx_q            <= ser_idx_q + 1'b1;
                        o_first_channel_flag <= 1'b0;             // [RULE20]
                        bit_q                <= `AROP_BITS_PER_CH;
                     end else begin
                        bit_q <= bit_q + 5'h01;
                     end
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
         // a joined select and read falls in the very cycle that leaves idle,
         // so the read is taken outside the state walk, and after it so it wins
         if (par_rd) begin                                        // [RULE5] [RULE7]
            if (if_mode == `AROP_IF_BYTE) begin                   // [RULE8]
               o_result_bus <= {8'h00,
                  pick_byte(res_q[ptr_q], high_byte_first, byte_hi_q)}; // [RULE10] [RULE11]
               byte_hi_q <= !byte_hi_q;
               if (byte_hi_q) begin
                  ptr_q <= ptr_q + 1'b1;
               end
            end else begin
               o_result_bus <= res_q[ptr_q];
               ptr_q        <= ptr_q + 1'b1;
            end
            // both channel 1 bytes go out with the flag still high
            o_first_channel_flag    <= (ptr_q == 2'h0);           // [RULE12]
            o_first_channel_flag_oe <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== arop_defines.vh
// constants for the adc result readout port
`ifndef AROP_DEFINES_VH
`define AROP_DEFINES_VH
`define AROP_CHANNELS      4
`define AROP_CH_W          2
`define AROP_RES_W         16
`define AROP_BITS_PER_CH   5'h10
`define AROP_IF_PAR16      2'h0
`define AROP_IF_SERIAL     2'h1
`define AROP_IF_BYTE       2'h3
`define AROP_FIFO_DEPTH    4
`define AROP_FIFO_AW       2
`endif

// ===== arop_fifo.v
// small flip-flop fifo carrying converter results into the output registers
`timescale 1ns/1ns
`default_nettype none
module arop_fifo #(
   parameter WIDTH = 64,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // clock and reset
   input  wire             i_clk,
   input  wire             i_rst,
   // write side
   input  wire             i_wr_valid,
   output wire             o_wr_ready,
   input  wire [WIDTH-1:0] i_wr_data,
   // read side
   output wire             o_rd_valid,
   input  wire             i_rd_ready,
   output wire [WIDTH-1:0] o_rd_data
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wp_q;
   reg [AW-1:0]    rp_q;
   reg [AW:0]      cnt_q;
   wire            do_wr;
   wire            do_rd;
   integer         k;

   assign o_wr_ready = (cnt_q != DEPTH[AW:0]);
   assign o_rd_valid = (cnt_q != {(AW+1){1'b0}});
   assign o_rd_data  = mem_q[rp_q];
   assign do_wr      = i_wr_valid && o_wr_ready;
   assign do_rd      = o_rd_valid && i_rd_ready;

   always @(posedge i_clk) begin
      if (i_rst) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         for (k = 0; k < DEPTH; k = k + 1) begin
            mem_q[k] <= {WIDTH{1'b0}};
         end
      end else begin
         if (do_wr) begin
            mem_q[wp_q] <= i_wr_data;
            wp_q        <= wp_q + 1'b1;
         end
         if (do_rd) begin
            rp_q <= rp_q + 1'b1;
         end
         if (do_wr && !do_rd) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (do_rd && !do_wr) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== arop_readout_sva.sv
// concurrent checks on the readout port pins
`timescale 1ns/1ns
`default_nettype none
module arop_readout_sva (
   // clock, reset and host pins
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_interface_select,
   input  wire        i_cs_n,
   input  wire        i_rd_n,
   input  wire        i_sclk,
   input  wire [15:0] i_result_bus,
   // pin outputs
   input  wire [15:0] o_result_bus_oe,
   input  wire        o_serial_out_a,
   input  wire        o_serial_out_a_oe,
   input  wire        o_serial_out_b,
   input  wire        o_serial_out_b_oe,
   input  wire        o_first_channel_flag_oe
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // host pins pass two sync stages, so each window leaves at least four clocks of lag
   wire ser = i_interface_select && !i_result_bus[15];
   chk_par_float: assert property (
      (!i_interface_select && (i_cs_n || i_rd_n)) [*6] |-> o_result_bus_oe == 16'h0000)
      else $error("result bus driven while not read");
   chk_par_drive: assert property (
      (!i_interface_select && !i_cs_n && !i_rd_n) [*6] |-> o_result_bus_oe == 16'hFFFF)
      else $error("result bus not driven during read");
   chk_cs_float: assert property (
      $rose(i_cs_n) ##1 i_cs_n [*4] |-> o_result_bus_oe == 16'h0000 && !o_serial_out_a_oe
         && !o_serial_out_b_oe)
      else $error("outputs still driven after deselect");
   chk_byte_low: assert property (
      i_interface_select && i_result_bus[15] |-> o_result_bus_oe[15:8] == 8'h00)
      else $error("byte mode drives upper lines");
   chk_ser_nobus: assert property (
      ser [*5] |-> o_result_bus_oe == 16'h0000)
      else $error("serial mode drives result bus");
   chk_flag_float: assert property (
      (ser && i_cs_n) [*5] |-> !o_first_channel_flag_oe)
      else $error("flag driven while deselected");
   chk_ser_release: assert property (
      ser && $fell(i_cs_n) ##1 !i_cs_n [*4] |-> o_serial_out_a_oe && o_serial_out_b_oe)
      else $error("serial lines not released by select");
   chk_ser_hold: assert property (
      (ser && !i_cs_n && $stable(i_sclk)) [*6] |-> $stable(o_serial_out_a)
         && $stable(o_serial_out_b))
      else $error("serial data moved without clock edge");
   cov_par_read: cover property (!i_interface_select && !i_cs_n && !i_rd_n);
   cov_byte_read: cover property (i_interface_select && i_result_bus[15] && !i_rd_n);
   cov_ser_frame: cover property (ser && $fell(i_cs_n));
endmodule
bind arop_readout arop_readout_sva arop_readout_sva_i (.*);
`default_nettype wire

// ===== arop_host.sv
// host model: read strobes and serial clock on the far side of the port
`timescale 1ns/1ns
`default_nettype none
module arop_host (
   // clock and lines from the port
   input  wire        i_clk,
   input  wire [15:0] i_bus,
   input  wire        i_sa,
   input  wire        i_sb,
   input  wire        i_flag,
   // strobes
   output logic       o_cs_n,
   output logic       o_rd_n,
   output logic       o_sclk
);
   // serial clock idles high so the first falling edge takes the msb
   initial begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_sclk = 1'b1;
   end
   task automatic set_cs(input logic v);
      @(negedge i_clk);
      o_cs_n = v;
      repeat (8) @(negedge i_clk);
   endtask
   // joined ties select to the strobe; callers never read across a busy fall
   task automatic rd_pulse(input logic joined, output logic [15:0] d, output logic fl);
      @(negedge i_clk);
      if (joined) o_cs_n = 1'b0;
      o_rd_n = 1'b0;
      repeat (8) @(negedge i_clk);
      d = i_bus;
      fl = i_flag;
      o_rd_n = 1'b1;
      if (joined) o_cs_n = 1'b1;
      repeat (8) @(negedge i_clk);
   endtask
   // one frame of n clocks, each bit taken on a falling edge
   task automatic ser_read(input int n, output logic [63:0] a, output logic [63:0] b,
                           output logic [63:0] f);
      a = '0;
      b = '0;
      f = '0;
      @(negedge i_clk);
      o_cs_n = 1'b0;
      repeat (6) @(negedge i_clk);
      for (int i = 0; i < n; i++) begin
         o_sclk = 1'b0;
         a = {a[62:0], i_sa};
         b = {b[62:0], i_sb};
         f = {f[62:0], i_flag};
         repeat (5) @(negedge i_clk);
         o_sclk = 1'b1;
         repeat (5) @(negedge i_clk);
      end
      o_cs_n = 1'b1;
      repeat (8) @(negedge i_clk);
   endtask
endmodule
`default_nettype wire

// ===== arop_readout_tb.sv
// testbench for the adc result readout port
`timescale 1ns/1ns
`default_nettype none
`include "arop_defines.vh"
module arop_readout_tb;
   localparam logic [63:0] W1 = 64'h1728_E5F6_C3D4_A1B2;
   localparam logic [63:0] W2 = 64'h8E3C_5A0F_D2B7_4961;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        busy = 1'b0;
   logic [63:0] conv = 64'h0;
   logic        conv_valid = 1'b0;
   logic        isel = 1'b0;
   logic        bm = 1'b0;
   logic        hbf = 1'b0;
   logic        tog = 1'b0;
   logic [63:0] a, b, f;
   logic [15:0] d;
   logic        fb;
   int          bad_count = 0;
   int          check_count = 0;
   wire         cs_n, rd_n, sclk, sa, sa_oe, sb, sb_oe, fl, fl_oe;
   wire  [15:0] bus_o, bus_oe, bus_w;
   wire         rdy;
   always #4 clk = ~clk;
   always @(posedge clk) tog <= ~tog;
   // undriven lines 13 to 0 carry a moving pattern so a stale level cannot pass; lines 15 and 14 carry the byte mode straps
   assign bus_w = (bus_o & bus_oe) | ({bm, hbf, {14{tog}}} & ~bus_oe);
   arop_readout arop_readout_i (.i_clk(clk), .i_rst(rst), .i_busy(busy),
      .i_conv_results(conv), .i_conv_valid(conv_valid), .o_conv_ready(rdy),
      .i_interface_select(isel), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_sclk(sclk),
      .i_result_bus(bus_w), .o_result_bus(bus_o), .o_result_bus_oe(bus_oe),
      .o_serial_out_a(sa), .o_serial_out_a_oe(sa_oe), .o_serial_out_b(sb),
      .o_serial_out_b_oe(sb_oe), .o_first_channel_flag(fl), .o_first_channel_flag_oe(fl_oe));
   arop_host arop_host_i (.i_clk(clk), .i_bus(bus_w), .i_sa(sa_oe ? sa : tog),
      .i_sb(sb_oe ? sb : tog), .i_flag(fl_oe ? fl : tog), .o_cs_n(cs_n), .o_rd_n(rd_n),
      .o_sclk(sclk));
   function automatic logic [15:0] ch(input logic [63:0] w, input int i);
      return w[16*(i%4) +: 16];
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // hold leaves busy high so a read can land inside the conversion
   task automatic push_load(input logic [63:0] w, input logic hold);
      @(negedge clk);
      conv = w;
      conv_valid = 1'b1;
      @(negedge clk);
      conv_valid = 1'b0;
      busy = 1'b1;
      repeat (10) @(negedge clk);
      if (!hold) busy = 1'b0;
      repeat (10) @(negedge clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      results();
   end
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      check({bus_oe, sa_oe, sb_oe, fl_oe}, 64'h0);
      check(rdy, 1'b1);
      push_load(W1, 1'b0);
      arop_host_i.set_cs(1'b0);
      for (int i = 0; i < `AROP_CHANNELS; i++) begin
         arop_host_i.rd_pulse(1'b0, d, fb);
         check(d, ch(W1, i));
         check(fb, i == 0);
         check(bus_oe, 16'h0000);
      end
      arop_host_i.set_cs(1'b1);
      push_load(W2, 1'b1);
      arop_host_i.rd_pulse(1'b1, d, fb);
      check(d, ch(W1, 0));
      check(fb, 1'b1);
      busy = 1'b0;
      repeat (10) @(negedge clk);
      for (int i = 0; i < 2; i++) begin
         arop_host_i.rd_pulse(1'b1, d, fb);
         check(d, ch(W2, i));
         check(fb, i == 0);
      end
      isel = 1'b1;
      bm = 1'b1;
      for (int h = 0; h < 2; h++) begin
         hbf = h[0];
         push_load(W1, 1'b0);
         arop_host_i.set_cs(1'b0);
         for (int i = 0; i < 2 * `AROP_CHANNELS; i++) begin
            arop_host_i.rd_pulse(1'b0, d, fb);
            check(d[7:0], (i % 2 == h) ? ch(W1, i / 2) & 16'h00FF : ch(W1, i / 2) >> 8);
            check(fb, i < 2);
         end
         arop_host_i.set_cs(1'b1);
      end
      bm = 1'b0;
      hbf = 1'b0;
      push_load(W1, 1'b0);
      arop_host_i.ser_read(64, a, b, f);
      check(a, {ch(W1, 0), ch(W1, 1), ch(W1, 2), ch(W1, 3)});
      check(b, {ch(W1, 2), ch(W1, 3), ch(W1, 0), ch(W1, 1)});
      check({f[63], f[47], f[31], f[15]}, 4'b1000);
      check({sa_oe, sb_oe, fl_oe}, 3'b000);
      push_load(W2, 1'b0);
      for (int i = 0; i < `AROP_CHANNELS; i++) begin
         arop_host_i.ser_read(16, a, b, f);
         check({a[15:0], b[15:0]}, {ch(W2, i), ch(W2, i + 2)});
      end
      results();
   end
endmodule
`default_nettype wire
